// *** flash_backdoor_pkg.sv ***
// Function
// - security field value 10 alone means unsecured; 00, 01, 11 are secured.
// - factory reserved register at 0x0002 reads zero and ignores writes.
// - while key access bit is set, flash array reads return invalid data.
// - backdoor sequence accepted only when backdoor enable field holds 10.
// - four matching words followed by clearing key access unsecure the device, forcing security field to 10.
// - any mismatching key word locks the machine, device stays secured.
// - key words out of address order lock the machine.
// - more than four key words in one sequence lock the machine.
// - key word 0x0000 or 0xFFFF locks the machine.
// - clearing key access after one to three words are written locks the machine.
// - lock holds until reset; reset permits a fresh sequence.
// - unlock leaves security byte at 0xFF0F alone; reset reloads from it.
// - stored key words at 0xFF00 to 0xFF07 stay unchanged.
// - sequence leaves protection register settings unchanged.
// - special single chip mode from background debug cannot unsecure if it is already seen when the first key word is written.
// - options register: backdoor enable bits 7-6, security bits 1-0.
package flash_backdoor_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  FLASH_CONFIG_OFS    = 8'h01;
  localparam logic [7:0]  FACTORY_TEST_OFS    = 8'h02;
  localparam logic [7:0]  SECURITY_OPT_OFS    = 8'h03;
  localparam logic [7:0]  PROTECTION_OFS      = 8'h04;
  localparam logic [7:0]  IRQ_STATUS_OFS      = 8'h05;
  localparam logic [7:0]  IRQ_MASK_OFS        = 8'h06;
  localparam logic [7:0]  SEC_STATE_OFS       = 8'h07;
  localparam int          KEY_ACCESS_BIT      = 5;
  localparam int          BACKDOOR_ENABLE_FIELD_HI            = 7;
  localparam int          BACKDOOR_ENABLE_FIELD_LO            = 6;
  localparam int          SEC_HI              = 1;
  localparam int          SEC_LO              = 0;
  localparam logic [1:0]  SEC_UNSECURED       = 2'h2;
  localparam logic [1:0]  BACKDOOR_ENABLE_FIELD_ENABLED       = 2'h2;
  localparam logic [15:0] KEY_BASE_ADDR       = 16'hFF00;
  localparam logic [15:0] SEC_BYTE_ADDR       = 16'hFF0F;
  localparam logic [15:0] KEY_ALL_ZERO        = 16'h0000;
  localparam logic [15:0] KEY_ALL_ONE         = 16'hFFFF;
  localparam logic [15:0] INVALID_READ_DATA   = 16'hFFFF;
  localparam logic [7:0]  CONFIG_RESET        = 8'h00;
  localparam logic [7:0]  OPTIONS_RESET       = 8'h01;
  localparam logic [7:0]  PROTECTION_RESET    = 8'hFF;
  localparam logic [2:0]  IRQ_RESET           = 3'h0;
  localparam int          IRQ_UNLOCK          = 0;
  localparam int          IRQ_LOCK            = 1;
  localparam int          IRQ_REFUSED         = 2;
  localparam int          KEY_WORDS           = 4;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_COLLECT  = 3'b001,
    ST_UNSECURE = 3'b010,
    ST_LOCKED   = 3'b011
  } sec_state_t;
endpackage

// *** flash_backdoor_unlock.sv ***
`timescale 1ns/1ps
module flash_backdoor_unlock (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [15:0] array_addr_in,
  input  wire logic [15:0] array_wdata_in,
  input  wire logic        array_wr_in,
  input  wire logic        array_rd_in,
  output logic [15:0]      array_rdata_out,
  input  wire logic [15:0] mem_rdata_in,
  input  wire logic [7:0]  nv_security_byte_in,
  input  wire logic [63:0] nv_backdoor_key_in,
  input  wire logic        special_single_chip_in,
  input  wire logic        background_debug_in,
  output logic [1:0]       security_state_field_out,
  output logic             secured_out,
  output logic             irq_out
);
  import flash_backdoor_pkg::*;

  // ****************************************************************
  // state and registers
  // ****************************************************************
  localparam logic [1:0] LAST_WORD = 2'(KEY_WORDS - 1);

  sec_state_t  state_reg;
  sec_state_t  state_next;
  logic [7:0]  flash_config_reg;
  logic [7:0]  protection_reg;
  logic [7:0]  security_options_reg;
  logic [1:0]  word_cnt_reg;
  logic [1:0]  word_cnt_next;
  logic        load_done_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_mask_reg;
  logic        key_access_prev_reg;
  logic        single_chip_meta_reg;
  logic        single_chip_sync_reg;
  logic        debug_meta_reg;
  logic        debug_sync_reg;
  logic [15:0] key_word [KEY_WORDS];
  logic        config_wr;
  logic        protection_wr;
  logic        status_wr;
  logic        mask_wr;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic        key_access_bit;
  logic        backdoor_ok;
  logic        key_write;
  logic [15:0] expect_word;
  logic [15:0] expect_addr;
  logic        word_bad;
  logic        fall_event;
  logic        unlock_event;
  logic        lock_event;
  logic        refuse_event;

  // ****************************************************************
  // mode pin synchronisers
  // ****************************************************************
  // mode levels arrive from pins; two flops keep a metastable level out of the gate.
  // they come out of reset high so the backdoor stays refused until the pins are seen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      single_chip_meta_reg <= 1'b1;
      single_chip_sync_reg <= 1'b1;
      debug_meta_reg       <= 1'b1;
      debug_sync_reg       <= 1'b1;
    end else begin
      single_chip_meta_reg <= special_single_chip_in;
      single_chip_sync_reg <= single_chip_meta_reg;
      debug_meta_reg       <= background_debug_in;
      debug_sync_reg       <= debug_meta_reg;
    end
  end

  // ****************************************************************
  // key words and decodes
  // ****************************************************************
  // the stored key is only read here, never written back
  genvar gi;
  generate
    for (gi = 0; gi < KEY_WORDS; gi++) begin : g_key_word
      assign key_word[gi] = nv_backdoor_key_in[16 * gi +: 16];
    end
  endgenerate

  assign config_wr     = reg_wr_in && (reg_addr_in == FLASH_CONFIG_OFS);
  assign protection_wr = reg_wr_in && (reg_addr_in == PROTECTION_OFS);
  assign status_wr     = reg_wr_in && (reg_addr_in == IRQ_STATUS_OFS);
  assign mask_wr       = reg_wr_in && (reg_addr_in == IRQ_MASK_OFS);

  assign key_access_bit = flash_config_reg[KEY_ACCESS_BIT];
  assign backdoor_ok = (security_options_reg[BACKDOOR_ENABLE_FIELD_HI:BACKDOOR_ENABLE_FIELD_LO] == BACKDOOR_ENABLE_FIELD_ENABLED)
                       && !(single_chip_sync_reg && debug_sync_reg);
  // key words are 16-bit aligned words; any array write while collecting counts
  assign key_write   = array_wr_in && key_access_bit;
  assign expect_word = key_word[word_cnt_reg];
  assign expect_addr = KEY_BASE_ADDR | {13'h0000, word_cnt_reg, 1'b0};
  assign word_bad    = (array_addr_in != expect_addr) || (array_wdata_in != expect_word)
                       || (array_wdata_in == KEY_ALL_ZERO) || (array_wdata_in == KEY_ALL_ONE);
  assign fall_event  = key_access_prev_reg && !key_access_bit;

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flash_config_reg <= CONFIG_RESET;
    end else if (config_wr) begin
      flash_config_reg <= reg_wdata_in;
    end
  end

  // protection only follows software writes, never the sequence
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      protection_reg <= PROTECTION_RESET;
    end else if (protection_wr) begin
      protection_reg <= reg_wdata_in;
    end
  end

  // options image loaded from the nonvolatile byte one cycle after reset release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_done_reg        <= 1'b0;
      security_options_reg <= OPTIONS_RESET;
    end else if (!load_done_reg) begin
      load_done_reg        <= 1'b1;
      security_options_reg <= nv_security_byte_in;
    end else if (unlock_event) begin
      security_options_reg[SEC_HI:SEC_LO] <= SEC_UNSECURED;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      key_access_prev_reg <= 1'b0;
    end else begin
      key_access_prev_reg <= key_access_bit;
    end
  end

  // ****************************************************************
  // security state machine
  // ****************************************************************
  // a disabled backdoor only flags the attempt; it does not lock, so a later
  // enable after reset is not blocked by a stray write
  always_comb begin
    unlock_event  = 1'b0;
    lock_event    = 1'b0;
    refuse_event  = 1'b0;
    state_next    = state_reg;
    word_cnt_next = word_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (key_write) begin
          if (!backdoor_ok) begin
            refuse_event = 1'b1;
          end else if (word_bad) begin
            lock_event = 1'b1;
            state_next = ST_LOCKED;
          end else begin
            state_next    = ST_COLLECT;
            word_cnt_next = 2'h1;
          end
        end
      end
      ST_COLLECT: begin
        if (key_write) begin
          if (word_bad) begin
            lock_event = 1'b1;
            state_next = ST_LOCKED;
          end else begin
            word_cnt_next = word_cnt_reg + 2'h1;
            if (word_cnt_reg == LAST_WORD) begin
              state_next = ST_UNSECURE;
            end
          end
        end else if (fall_event) begin
          lock_event = 1'b1;
          state_next = ST_LOCKED;
        end
      end
      ST_UNSECURE: begin
        // four good words are in; the verdict waits for key access to drop
        if (key_write) begin
          lock_event = 1'b1;
          state_next = ST_LOCKED;
        end else if (fall_event) begin
          unlock_event  = 1'b1;
          state_next    = ST_IDLE;
          word_cnt_next = 2'h0;
        end
      end
      ST_LOCKED: begin
        refuse_event = key_write;
      end
      default: begin
        lock_event = 1'b1;
        state_next = ST_LOCKED;
      end
    endcase
  end

  // only reset leaves ST_LOCKED
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg    <= ST_IDLE;
      word_cnt_reg <= 2'h0;
    end else begin
      state_reg    <= state_next;
      word_cnt_reg <= word_cnt_next;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set = {refuse_event, lock_event, unlock_event};
  assign irq_clr = status_wr ? reg_wdata_in[2:0] : 3'h0;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      // set wins over the write-one clear, so an event is never lost
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (mask_wr) begin
      irq_mask_reg <= reg_wdata_in[2:0];
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // ****************************************************************
  // read paths
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        FLASH_CONFIG_OFS: reg_rdata_out <= flash_config_reg;
        FACTORY_TEST_OFS: reg_rdata_out <= 8'h00;
        SECURITY_OPT_OFS: reg_rdata_out <= security_options_reg;
        PROTECTION_OFS:   reg_rdata_out <= protection_reg;
        IRQ_STATUS_OFS:   reg_rdata_out <= {5'h00, irq_status_reg};
        IRQ_MASK_OFS:     reg_rdata_out <= {5'h00, irq_mask_reg};
        SEC_STATE_OFS:    reg_rdata_out <= {5'h00, state_reg};
        default:          reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // key words are never written into the array by this block
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      array_rdata_out <= 16'h0000;
    end else if (array_rd_in) begin
      array_rdata_out <= key_access_bit ? INVALID_READ_DATA : mem_rdata_in;
    end
  end

  assign security_state_field_out = security_options_reg[SEC_HI:SEC_LO];
  assign secured_out = (security_options_reg[SEC_HI:SEC_LO] != SEC_UNSECURED);

endmodule // flash_backdoor_unlock

// *** flash_backdoor_unlock_chk.sv ***
`timescale 1ns/1ps
module flash_backdoor_unlock_chk (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        array_rd_in,
  input wire logic [15:0] array_rdata_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic [7:0]  nv_security_byte_in,
  input wire logic        special_single_chip_in,
  input wire logic        background_debug_in,
  input wire logic [1:0]  security_state_field_out,
  input wire logic        secured_out
);
  // ********
  // key access mirror, rebuilt from register writes
  // ********
  logic kacc_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) kacc_reg <= 1'b0;
    else if (reg_wr_in && reg_addr_in == 8'h01) kacc_reg <= reg_wdata_in[5];
  end
  a_reserved_reads_zero: assert property (reg_rd_in && reg_addr_in == 8'h02
    |=> reg_rdata_out == 8'h00) else $error("reserved register read nonzero");
  a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read");
  a_secured_decode: assert property (secured_out == (security_state_field_out != 2'b10))
    else $error("secured flag disagrees with field");
  a_read_invalid: assert property (array_rd_in && kacc_reg
    |=> array_rdata_out == 16'hFFFF) else $error("array data leaked during key access");
  a_read_passes: assert property (array_rd_in && !kacc_reg
    |=> array_rdata_out == $past(mem_rdata_in)) else $error("array read data wrong");
  a_array_data_holds: assert property (!array_rd_in |=> $stable(array_rdata_out))
    else $error("array read data moved without read");
  a_unlock_gated: assert property ($rose(security_state_field_out == 2'b10)
    && $past(rst_n_in, 2) |-> nv_security_byte_in[7:6] == 2'b10 && !kacc_reg
    && !(special_single_chip_in && background_debug_in)) else $error("unlock not allowed");
  a_field_only_unlocks: assert property ($changed(security_state_field_out)
    && $past(rst_n_in, 2) |-> security_state_field_out == 2'b10) else $error("bad field change");
endmodule // flash_backdoor_unlock_chk

// *** flash_cpu_model.sv ***
`timescale 1ns/1ps
module flash_cpu_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic [15:0]      addr_out,
  output logic [15:0]      wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  // ********
  // cpu side of the flash array
  // ********
  initial begin
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // released bus shows the inverse so a stale word never looks like a fresh key
  task put(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task get(input logic [15:0] a, output logic [15:0] q);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 q = rdata_in;
  endtask
endmodule // flash_cpu_model

// *** tb_flash_backdoor_unlock.sv ***
`timescale 1ns/1ps
module tb_flash_backdoor_unlock;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        special_single_chip_in = 1'b0, background_debug_in = 1'b0;
  logic        secured_out, irq_out, array_wr_in, array_rd_in;
  logic [1:0]  security_state_field_out;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [7:0]  nv_security_byte_in = 8'h81;
  logic [15:0] mem_rdata_in = 16'h1234, array_addr_in, array_wdata_in, array_rdata_out;
  logic [63:0] nv_backdoor_key_in = 64'h4444_3333_2222_1111;
  int          err_total = 0, n_compared = 0;
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) mem_rdata_in <= mem_rdata_in + 16'h0101;
  flash_cpu_model cpu_u (.clk_in, .rdata_in(array_rdata_out), .addr_out(array_addr_in),
    .wdata_out(array_wdata_in), .wr_out(array_wr_in), .rd_out(array_rd_in));
  flash_backdoor_unlock dut_u (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .array_addr_in, .array_wdata_in, .array_wr_in, .array_rd_in,
    .array_rdata_out, .mem_rdata_in, .nv_security_byte_in, .nv_backdoor_key_in,
    .special_single_chip_in, .background_debug_in, .security_state_field_out,
    .secured_out, .irq_out);
  // ********
  // shared tasks
  // ********
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk({8'h00, reg_rdata_out}, {8'h00, e});
  endtask
  task do_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
  // kind 0 is clean; 1..6 each break the sequence in one way
  task attempt(input int kind);
    logic [15:0] a, d, q;
    wr_reg(8'h01, 8'h20);
    for (int i = 0; i < 4; i++) begin
      a = 16'hFF00 + 16'(2 * i);
      d = nv_backdoor_key_in[16 * i +: 16];
      if (kind == 1 && i == 1) d = d ^ 16'h0100;
      if (kind == 2 && i == 2) d = 16'hFFFF;
      if (kind == 3 && i == 3) d = 16'h0000;
      if (kind == 4 && i == 1) a = 16'hFF04;
      if (kind != 6 || i < 2) cpu_u.put(a, d);
    end
    if (kind == 5) cpu_u.put(16'hFF08, nv_backdoor_key_in[15:0]);
    cpu_u.get(16'h8000, q);
    chk(q, 16'hFFFF);
    wr_reg(8'h01, 8'h00);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // ********
  // scenarios
  // ********
  task t_reset;
    rd_reg(8'h02, 8'h00);
    wr_reg(8'h02, 8'hFF);
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h03, 8'h81);
    rd_reg(8'h0F, 8'h00);
    chk(16'(security_state_field_out), 16'h0001);
    $display("reset test done");
  endtask
  task t_unlock;
    wr_reg(8'h06, 8'h03);
    attempt(0);
    chk(16'(security_state_field_out), 16'h0002);
    chk(16'(secured_out), 16'h0000);
    rd_reg(8'h04, 8'hFF);
    rd_reg(8'h05, 8'h01);
    for (int n = 0; n < 8 && irq_out !== 1'b1; n++) @(negedge clk_in);
    chk(16'(irq_out), 16'h0001);
    if (irq_out !== 1'b1) end_sim;
    wr_reg(8'h06, 8'h00);
    repeat (2) @(negedge clk_in);
    chk(16'(irq_out), 16'h0000);
    wr_reg(8'h06, 8'h03);
    wr_reg(8'h05, 8'h01);
    repeat (2) @(negedge clk_in);
    chk(16'(irq_out), 16'h0000);
    do_reset;
    chk(16'(security_state_field_out), 16'h0001);
    $display("unlock test done");
  endtask
  task t_illegal;
    for (int k = 1; k < 7; k++) begin
      attempt(k);
      chk(16'(security_state_field_out), 16'h0001);
      rd_reg(8'h07, 8'h03);
      attempt(0);
      chk(16'(security_state_field_out), 16'h0001);
      rd_reg(8'h05, 8'h06);
      do_reset;
    end
    attempt(0);
    chk(16'(security_state_field_out), 16'h0002);
    $display("illegal test done");
  endtask
  task t_refused;
    for (int j = 0; j < 4; j++) begin
      nv_security_byte_in <= {2'(j), 6'h01};
      do_reset;
      attempt(0);
      chk(16'(security_state_field_out), (j == 2) ? 16'h0002 : 16'h0001);
      rd_reg(8'h05, (j == 2) ? 8'h01 : 8'h04);
    end
    nv_security_byte_in <= 8'h81;
    special_single_chip_in <= 1'b1;
    background_debug_in <= 1'b1;
    do_reset;
    attempt(0);
    chk(16'(security_state_field_out), 16'h0001);
    rd_reg(8'h05, 8'h04);
    $display("refused test done");
  endtask
  initial begin
    do_reset;
    t_reset;
    t_unlock;
    t_illegal;
    t_refused;
    end_sim;
  end
endmodule // tb_flash_backdoor_unlock
bind flash_backdoor_unlock flash_backdoor_unlock_chk chk_u (.clk_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .array_rd_in, .array_rdata_out,
  .mem_rdata_in, .nv_security_byte_in, .special_single_chip_in, .background_debug_in,
  .security_state_field_out, .secured_out);
